// file: design/power_event_irq_regs.v
// Power event and interrupt register bank on an APB slave.
// Assumes a 32-bit APB master and event pulses synchronous to pclk.
//
// Contract
// - Writing one to low_power_task selects variable-latency low-power mode
// - Writing one to constant_latency_task selects constant-latency mode
// - Power-fail warning event reads one once generated, else zero
// - Sleep-entry event sets when the processor enters sleep
// - Sleep-exit event reads one after the processor leaves sleep
// - Enable-set bit zero enables the power-fail warning interrupt
// - Enable-set bit one enables the sleep-entry interrupt
// - Enable-set bit two enables the sleep-exit interrupt
// - Enable-clear bit zero disables the power-fail warning interrupt
// - Enable-clear bit one disables the sleep-entry interrupt
// - Enable-clear bit two disables the sleep-exit interrupt
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "power_event_map.vh"
module power_event_irq_regs #(
  parameter ADDR_WIDTH = 12
) (
  // Clock and reset
  input  wire                  pclk,
  input  wire                  presetn,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [ADDR_WIDTH-1:0] paddr,
  input  wire [31:0]           pwdata,
  input  wire [3:0]            pstrb,
  output wire                  pready,
  output reg  [31:0]           prdata,
  output wire                  pslverr,
  // Event sources
  input  wire                  power_fail_warning,
  input  wire                  sleep_entry,
  input  wire                  sleep_exit_a,
  // Power mode and interrupt
  output reg                   low_power_mode,
  output wire                  irq
);

  wire       wr_phase;
  wire       rd_phase;
  wire       known;
  wire [2:0] enable_reg;
  wire       warn_flag;
  wire       entry_flag;
  wire       exit_flag;
  reg        low_power_mode_next;
  reg [31:0] prdata_next;

  // Address match at the register offsets
  function hit;
    input [ADDR_WIDTH-1:0] addr;
    input [11:0]           off;
    begin
      hit = (addr == off[ADDR_WIDTH-1:0]);
    end
  endfunction

  // Zero-wait slave; writes land at the access edge
  assign pready   = 1'b1;
  assign wr_phase = psel & penable & pwrite;
  assign rd_phase = psel & ~penable & ~pwrite;
  assign known = hit(paddr, `CONSTANT_LATENCY_TASK_OFF) |
                 hit(paddr, `LOW_POWER_TASK_OFF) |
                 hit(paddr, `POWER_FAIL_WARN_EVENT_OFF) |
                 hit(paddr, `SLEEP_ENTRY_EVENT_OFF) |
                 hit(paddr, `SLEEP_EXIT_EVENT_OFF) |
                 hit(paddr, `INT_ENABLE_SET_OFF) |
                 hit(paddr, `INT_ENABLE_CLEAR_OFF) |
                 hit(paddr, `LATENCY_MODE_OFF);
  // Unmapped addresses answer with an error, nothing changes
  assign pslverr  = psel & penable & ~known;

  // Event flags; the set beats a software write in the same cycle
  event_flag u_warn (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set   (power_fail_warning),
    .sw_write (wr_phase & hit(paddr, `POWER_FAIL_WARN_EVENT_OFF)),
    .sw_value (pwdata[0]),
    .flag_reg (warn_flag)
  );

  event_flag u_entry (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set   (sleep_entry),
    .sw_write (wr_phase & hit(paddr, `SLEEP_ENTRY_EVENT_OFF)),
    .sw_value (pwdata[0]),
    .flag_reg (entry_flag)
  );

  event_flag u_exit (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set   (sleep_exit_a),
    .sw_write (wr_phase & hit(paddr, `SLEEP_EXIT_EVENT_OFF)),
    .sw_value (pwdata[0]),
    .flag_reg (exit_flag)
  );

  // Shared enable state for the set and clear views
  enable_bits #(
    .WIDTH (3)
  ) u_enable (
    .pclk        (pclk),
    .presetn     (presetn),
    .set_write   (wr_phase & hit(paddr, `INT_ENABLE_SET_OFF)),
    .clear_write (wr_phase & hit(paddr, `INT_ENABLE_CLEAR_OFF)),
    .wdata       (pwdata[2:0]),
    .enable_reg  (enable_reg)
  );

  // Interrupt is the OR of enabled events
  assign irq = (warn_flag  & enable_reg[`POWER_FAIL_WARNING_BIT]) |
               (entry_flag & enable_reg[`SLEEP_ENTRY_BIT]) |
               (exit_flag  & enable_reg[`SLEEP_EXIT_A_BIT]);

  // Mode selection; low power wins if both tasks could fire together
  always @* begin
    low_power_mode_next = low_power_mode;
    if (wr_phase && pwdata[0]) begin
      if (hit(paddr, `LOW_POWER_TASK_OFF)) begin
        low_power_mode_next = 1'b1;
      end else if (hit(paddr, `CONSTANT_LATENCY_TASK_OFF)) begin
        low_power_mode_next = 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_mode <= `LATENCY_MODE_RESET;
    end else begin
      low_power_mode <= low_power_mode_next;
    end
  end

  // Read data; task registers are write-only and read zero
  always @* begin
    prdata_next = 32'h0000_0000;
    if (hit(paddr, `POWER_FAIL_WARN_EVENT_OFF)) begin
      prdata_next[0] = warn_flag;
    end else if (hit(paddr, `SLEEP_ENTRY_EVENT_OFF)) begin
      prdata_next[0] = entry_flag;
    end else if (hit(paddr, `SLEEP_EXIT_EVENT_OFF)) begin
      prdata_next[0] = exit_flag;
    end else if (hit(paddr, `INT_ENABLE_SET_OFF) ||
                 hit(paddr, `INT_ENABLE_CLEAR_OFF)) begin
      prdata_next[2:0] = enable_reg;
    end else if (hit(paddr, `LATENCY_MODE_OFF)) begin
      prdata_next[0] = low_power_mode;
    end
  end

  // Capture in the setup cycle so data is stable in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_phase) begin
      prdata <= prdata_next;
    end
  end

endmodule // power_event_irq_regs

// file: design/power_event_map.vh
// Register map constants for the power event and interrupt block.
// Assumes byte addressing on a 32-bit APB with word-aligned registers.
`ifndef POWER_EVENT_MAP_VH
`define POWER_EVENT_MAP_VH

`define CONSTANT_LATENCY_TASK_OFF  12'h078
`define LOW_POWER_TASK_OFF         12'h07c
`define POWER_FAIL_WARN_EVENT_OFF  12'h108
`define SLEEP_ENTRY_EVENT_OFF      12'h114
`define SLEEP_EXIT_EVENT_OFF       12'h118
`define INT_ENABLE_SET_OFF         12'h304
`define INT_ENABLE_CLEAR_OFF       12'h308
`define LATENCY_MODE_OFF           12'h310

`define POWER_FAIL_WARNING_BIT     0
`define SLEEP_ENTRY_BIT            1
`define SLEEP_EXIT_A_BIT           2

`define EVENT_RESET                1'b0
`define ENABLE_RESET               3'h0
`define LATENCY_MODE_RESET         1'b0

`endif

// file: design/event_flag.v
// One sticky event flag: hardware sets, software writes to clear or set.
// Assumes the set pulse is synchronous to pclk.
`timescale 1ns/1ps
module event_flag (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Hardware event and software write
  input  wire hw_set,
  input  wire sw_write,
  input  wire sw_value,
  // Flag state
  output reg  flag_reg
);

  // Hardware set wins over a software clear so no event is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (hw_set) begin
      flag_reg <= 1'b1;
    end else if (sw_write) begin
      flag_reg <= sw_value;
    end
  end

endmodule // event_flag

// file: design/enable_bits.v
// Shared interrupt enable state behind a write-one-set and
// write-one-clear register pair.
// Assumes the write strobes are single-cycle APB write phases.
`timescale 1ns/1ps
module enable_bits #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Write strobes with data
  input  wire             set_write,
  input  wire             clear_write,
  input  wire [WIDTH-1:0] wdata,
  // Enable state
  output reg  [WIDTH-1:0] enable_reg
);

  // Zeros in the written word leave the matching enable untouched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= {WIDTH{1'b0}};
    end else if (set_write) begin
      enable_reg <= enable_reg | wdata;
    end else if (clear_write) begin
      enable_reg <= enable_reg & ~wdata;
    end
  end

endmodule // enable_bits

// file: tb/power_event_chk.sv
// Port checker for the power event register bank, bound to its top.
// Assumes 12-bit byte addresses and full-word APB writes.
`timescale 1ns/1ps
module power_event_chk (
  // Clock, reset and bus
  input wire        pclk, presetn, psel, penable, pwrite, irq,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // Events and mode
  input wire        power_fail_warning, sleep_entry, sleep_exit_a,
  input wire        low_power_mode
);
  wire       wr = psel && penable && pwrite;
  wire       rd = psel && penable && !pwrite;
  reg  [2:0] en;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Enable shadow; zero bits leave it alone
  always @(posedge pclk or negedge presetn)
    if (!presetn) en <= 3'h0;
    else if (wr && paddr == 12'h304) en <= en | pwdata[2:0];
    else if (wr && paddr == 12'h308) en <= en & ~pwdata[2:0];
  property p_lp; wr && paddr == 12'h07c && pwdata[0] |=> low_power_mode;
  endproperty
  a_lp: assert property (p_lp) else $error("low power not set");
  property p_cl; wr && paddr == 12'h078 && pwdata[0] |=> !low_power_mode;
  endproperty
  a_cl: assert property (p_cl) else $error("low power not left");
  property p_e0; power_fail_warning && en[0] && !wr |=> irq; endproperty
  a_e0: assert property (p_e0) else $error("warning irq missing");
  property p_e1; sleep_entry && en[1] && !wr |=> irq; endproperty
  a_e1: assert property (p_e1) else $error("entry irq missing");
  property p_e2; sleep_exit_a && en[2] && !wr |=> irq; endproperty
  a_e2: assert property (p_e2) else $error("exit irq missing");
  property p_rs; rd && paddr == 12'h304 |-> prdata[2:0] == en; endproperty
  a_rs: assert property (p_rs) else $error("set read wrong");
  property p_rc; rd && paddr == 12'h308 |-> prdata[2:0] == en; endproperty
  a_rc: assert property (p_rc) else $error("clear read wrong");
  property p_nq; en == 3'h0 |-> !irq; endproperty
  a_nq: assert property (p_nq) else $error("irq while masked");
  c_irq: cover property (irq);
  c_lp: cover property (wr && paddr == 12'h07c);
  c_rc: cover property (rd && paddr == 12'h308);
endmodule // power_event_chk

bind power_event_irq_regs power_event_chk power_event_chk_i (.*);

// file: tb/event_source.sv
// Model of the hardware event sources beside the register bank.
// Assumes fire is called just after a rising pclk edge.
`timescale 1ns/1ps
module event_source (
  // Clock
  input wire pclk,
  // Event pulses
  output reg power_fail_warning = 1'b0,
  output reg sleep_entry        = 1'b0,
  output reg sleep_exit_a       = 1'b0
);
  // One-cycle pulse, dropped at the next edge
  task fire(input [1:0] i);
    {sleep_exit_a, sleep_entry, power_fail_warning} <= 3'h1 << i;
    @(posedge pclk);
    {sleep_exit_a, sleep_entry, power_fail_warning} <= 3'h0;
  endtask
endmodule // event_source

// file: tb/tb_top.sv
// Self-checking bench for the power event register bank over APB.
// Assumes the slave may stall; every access waits for pready.
`timescale 1ns/1ps
module tb_top;
  reg         pclk = 1'b0, presetn = 1'b0, rerr;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0, rdat;
  wire        pready, pslverr, low_power_mode, irq;
  wire        power_fail_warning, sleep_entry, sleep_exit_a;
  wire [31:0] prdata;
  int         n_errors = 0, checks = 0, cyc = 0;
  logic [11:0] ra [5] = '{12'h108, 12'h114, 12'h118, 12'h304, 12'h308};
  event_source event_source_i (.*);
  power_event_irq_regs power_event_irq_regs_i (.*, .pstrb(4'hf));
  initial forever #5 pclk = ~pclk;
  // Cycle ceiling so a hung bus still ends the run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; #1 at the end lets the edge's updates land
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), rdat, exp);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], 32'h0);
    rd(12'h200, 32'h0);
    chk("pslverr", rerr, 1'b1);
    // Mode tasks: write-only, zero ignored, counterpart leaves
    apb(1'b1, 12'h07c, 32'h1);
    chk("mode", low_power_mode, 1'b1);
    rd(12'h07c, 32'h0);
    rd(12'h310, 32'h1);
    apb(1'b1, 12'h078, 32'h0);
    chk("mode", low_power_mode, 1'b1);
    apb(1'b1, 12'h078, 32'h1);
    chk("mode", low_power_mode, 1'b0);
    rd(12'h310, 32'h0);
    // Enable pair, back to back, zero writes in between
    apb(1'b1, 12'h304, 32'h5);
    apb(1'b1, 12'h308, 32'h0);
    apb(1'b1, 12'h304, 32'h0);
    rd(12'h304, 32'h5);
    apb(1'b1, 12'h308, 32'h1);
    rd(12'h308, 32'h4);
    apb(1'b1, 12'h308, 32'h7);
    // Each event: masked, enabled, cleared by zero, disabled
    for (int i = 0; i < 3; i++) begin
      event_source_i.fire(i[1:0]);
      #1 chk("irq", irq, 1'b0);
      rd(ra[i], 32'h1);
      apb(1'b1, 12'h304, 32'h1 << i);
      chk("irq", irq, 1'b1);
      rd(12'h304, 32'h1 << i);
      apb(1'b1, ra[i], 32'h0);
      chk("irq", irq, 1'b0);
      apb(1'b1, 12'h308, 32'h1 << i);
      rd(12'h308, 32'h0);
    end
    // Events arriving while already enabled raise irq at once
    apb(1'b1, 12'h304, 32'h7);
    for (int i = 0; i < 3; i++) begin
      event_source_i.fire(i[1:0]);
      #1 chk("irq on", irq, 1'b1);
      apb(1'b1, ra[i], 32'h0);
      chk("irq off", irq, 1'b0);
    end
    tally_and_finish;
  end
endmodule // tb_top
